// ==== inc/rpmc_pkg.sv ====
// Package for the receiver power mode control block: modes, ratios and pin levels.
package rpmc_pkg;

    // ==========================================================
    // Operating modes, one-hot.
    typedef enum logic [6:0] {
        RPMC_RESET    = 7'h01,
        RPMC_NORMAL   = 7'h02,
        RPMC_VCO_STOP = 7'h04,
        RPMC_AMP_ONLY = 7'h08,
        RPMC_DIV_ONLY = 7'h10,
        RPMC_AMP_STOP = 7'h20,
        RPMC_ALL_STOP = 7'h40
    } rpmc_mode_type;

    // ==========================================================
    // Field encodings.
    localparam logic [1:0] RPMC_SLEEP_NONE = 2'h0;
    localparam logic [1:0] RPMC_SLEEP_AMP  = 2'h1;
    localparam logic [1:0] RPMC_SLEEP_DIV  = 2'h2;

    localparam logic [1:0] RPMC_RATIO_256  = 2'h0;
    localparam logic [1:0] RPMC_RATIO_384  = 2'h1;
    localparam logic [1:0] RPMC_RATIO_512  = 2'h2;
    localparam logic [1:0] RPMC_RATIO_512H = 2'h3;

    // Lock multipliers of fs and sample-rate ceilings in kHz.
    localparam logic [9:0] RPMC_MULT_256   = 10'h100;
    localparam logic [9:0] RPMC_MULT_384   = 10'h180;
    localparam logic [9:0] RPMC_MULT_512   = 10'h200;
    localparam logic [7:0] RPMC_FS_MAX_WIDE   = 8'hc3;
    localparam logic [7:0] RPMC_FS_MAX_NARROW = 8'h6c;

    // ==========================================================
    // Control bits from the host.
    typedef struct packed {
        logic       osc_amp_stop;
        logic       vco_stop;
        logic [1:0] partial_sleep_select;
        logic [1:0] pll_lock_ratio;
    } rpmc_ctrl_type;

    // Pin levels driven out of the block.
    typedef struct packed {
        logic audio;
        logic user_port_out;
        logic master_clock_out;
        logic bit_clock_out;
        logic frame_clock_out;
        logic serial_audio_out;
        logic crystal_out;
        logic error;
        logic irq;
    } rpmc_pins_type;

    // Reset levels of the pins in the reset mode.
    localparam rpmc_pins_type RPMC_PINS_RESET = '{
        audio: 1'b0, user_port_out: 1'b1, master_clock_out: 1'b0,
        bit_clock_out: 1'b0, frame_clock_out: 1'b0, serial_audio_out: 1'b0,
        crystal_out: 1'b1, error: 1'b1, irq: 1'b0};

endpackage

// ==== verilog/rpmc_ratio.sv ====
// Lock ratio decoder: multiplier, output halving and sample-rate ceiling.
module rpmc_ratio (
    // Ratio field
    input  wire logic [1:0] i_ratio,
    // Decoded values
    output logic      [9:0] o_lock_mult,
    output logic            o_half_out,
    output logic      [7:0] o_fs_max_khz
);

    always_comb begin
        o_half_out   = 1'b0;
        o_fs_max_khz = rpmc_pkg::RPMC_FS_MAX_NARROW;
        unique case (i_ratio)
            rpmc_pkg::RPMC_RATIO_256: begin
                o_lock_mult  = rpmc_pkg::RPMC_MULT_256;
                o_fs_max_khz = rpmc_pkg::RPMC_FS_MAX_WIDE;
            end
            rpmc_pkg::RPMC_RATIO_384: begin
                o_lock_mult = rpmc_pkg::RPMC_MULT_384;
            end
            rpmc_pkg::RPMC_RATIO_512: begin
                o_lock_mult = rpmc_pkg::RPMC_MULT_512;
            end
            rpmc_pkg::RPMC_RATIO_512H: begin
                o_lock_mult = rpmc_pkg::RPMC_MULT_512;
                o_half_out  = 1'b1;
            end
        endcase
    end

endmodule // rpmc_ratio

// ==== verilog/rpmc_top.sv ====
// Power mode controller of the audio receiver: mode decode, clock source and pin states.
module rpmc_top (
    // Clock and power-down reset
    input  wire logic                    i_ref_clk,
    input  wire logic                    i_rst_n,
    // Host control
    input  wire rpmc_pkg::rpmc_ctrl_type i_ctrl,
    input  wire logic                    i_ctrl_we,
    // Status from the analogue and clock world
    input  wire logic                    i_pll_locked,
    input  wire logic                    i_clock_loopback,
    // Live pin levels in a running mode
    input  wire rpmc_pkg::rpmc_pins_type i_live_pins,
    // Readback of subcode and channel status
    input  wire logic [7:0]              i_status_data,
    output logic      [7:0]              o_status_data,
    // Mode and clock enables
    output rpmc_pkg::rpmc_mode_type      o_mode,
    output logic                         o_osc_amp_run,
    output logic                         o_divider_run,
    output logic                         o_vco_run,
    output logic                         o_use_pll_clock,
    output logic                         o_clock_out_en,
    // Lock ratio
    output logic      [9:0]              o_lock_mult,
    output logic                         o_half_out,
    output logic      [7:0]              o_fs_max_khz,
    // Pins
    output rpmc_pkg::rpmc_pins_type      o_pins
);

    // ==========================================================
    // State.
    typedef struct packed {
        rpmc_pkg::rpmc_ctrl_type ctrl;
        rpmc_pkg::rpmc_mode_type mode;
        rpmc_pkg::rpmc_pins_type pins;
        logic [7:0]              status;
    } rpmc_state_type;

    localparam rpmc_state_type RPMC_STATE_RESET = '{
        ctrl: '0, mode: rpmc_pkg::RPMC_RESET,
        pins: rpmc_pkg::RPMC_PINS_RESET, status: 8'h00};

    rpmc_state_type          state;
    rpmc_state_type          next_state;
    rpmc_pkg::rpmc_mode_type dec_mode;
    logic                    clocks_dead;

    // ==========================================================
    // Mode decode from the control bits.
    always_comb begin
        // Amplifier stop inside a sleep mode leaves no clock at all, so it is a full stop.
        if (state.ctrl.osc_amp_stop
                && (state.ctrl.vco_stop
                || (state.ctrl.partial_sleep_select != rpmc_pkg::RPMC_SLEEP_NONE))) begin
            dec_mode = rpmc_pkg::RPMC_ALL_STOP;
        end else if (state.ctrl.osc_amp_stop) begin
            dec_mode = rpmc_pkg::RPMC_AMP_STOP;
        end else if (state.ctrl.partial_sleep_select == rpmc_pkg::RPMC_SLEEP_AMP) begin
            dec_mode = rpmc_pkg::RPMC_AMP_ONLY;
        end else if (state.ctrl.partial_sleep_select == rpmc_pkg::RPMC_SLEEP_DIV) begin
            dec_mode = rpmc_pkg::RPMC_DIV_ONLY;
        end else if (state.ctrl.vco_stop) begin
            dec_mode = rpmc_pkg::RPMC_VCO_STOP;
        end else begin
            dec_mode = rpmc_pkg::RPMC_NORMAL;
        end
    end

    // Without a crystal clock or a locked PLL nothing can toggle.
    always_comb begin
        clocks_dead = 1'b0;
        unique case (state.mode)
            rpmc_pkg::RPMC_AMP_STOP: clocks_dead = !i_pll_locked;
            rpmc_pkg::RPMC_VCO_STOP,
            rpmc_pkg::RPMC_AMP_ONLY,
            rpmc_pkg::RPMC_DIV_ONLY: clocks_dead = i_clock_loopback;
            default:                 clocks_dead = 1'b0;
        endcase
    end

    // ==========================================================
    // Next state: control capture, mode and pin levels.
    always_comb begin
        next_state = state;
        if (i_ctrl_we) begin
            next_state.ctrl = i_ctrl;
        end
        next_state.mode = dec_mode;
        next_state.pins = i_live_pins;
        // Readback of subcode and status reads zero whenever a partial sleep mode is selected.
        next_state.status = (state.ctrl.partial_sleep_select != rpmc_pkg::RPMC_SLEEP_NONE)
                          ? 8'h00 : i_status_data;
        unique case (state.mode)
            rpmc_pkg::RPMC_NORMAL: begin
            end
            rpmc_pkg::RPMC_VCO_STOP, rpmc_pkg::RPMC_DIV_ONLY: begin
                next_state.pins.audio = 1'b0;
                next_state.pins.error = 1'b1;
                next_state.pins.irq   = 1'b0;
            end
            rpmc_pkg::RPMC_AMP_ONLY: begin
                next_state.pins.audio            = 1'b0;
                next_state.pins.error            = 1'b1;
                next_state.pins.irq              = 1'b0;
                next_state.pins.bit_clock_out    = 1'b0;
                next_state.pins.frame_clock_out  = 1'b0;
                next_state.pins.serial_audio_out = 1'b0;
            end
            rpmc_pkg::RPMC_AMP_STOP: begin
                next_state.pins.crystal_out = 1'b1;
            end
            rpmc_pkg::RPMC_ALL_STOP: begin
                next_state.pins                  = rpmc_pkg::RPMC_PINS_RESET;
                next_state.pins.user_port_out    = i_live_pins.user_port_out;
                // Bit and frame clocks freeze at whatever level they had on entry.
                next_state.pins.bit_clock_out    = state.pins.bit_clock_out;
                next_state.pins.frame_clock_out  = state.pins.frame_clock_out;
            end
            default: begin
                next_state.pins = rpmc_pkg::RPMC_PINS_RESET;
            end
        endcase
        // A dead clock drives the master clock low and leaves bit and frame clocks where they stood.
        // Sleep 01 keeps its forced lows even when the clock is lost.
        if (clocks_dead) begin
            next_state.pins.master_clock_out = 1'b0;
            if (state.mode != rpmc_pkg::RPMC_AMP_ONLY) begin
                next_state.pins.bit_clock_out   = state.pins.bit_clock_out;
                next_state.pins.frame_clock_out = state.pins.frame_clock_out;
            end
        end
    end

    // Power-down is the asynchronous reset of everything here.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= RPMC_STATE_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Clock enables and source choice.
    // Enables follow the registered mode and also i_pll_locked and i_clock_loopback directly, so not all move only with o_mode.
    always_comb begin
        o_osc_amp_run   = 1'b0;
        o_divider_run   = 1'b0;
        o_vco_run       = 1'b0;
        o_use_pll_clock = 1'b0;
        o_clock_out_en  = 1'b0;
        unique case (state.mode)
            rpmc_pkg::RPMC_RESET: begin
                // Power-down holds every clock of the block off.
                o_osc_amp_run = 1'b0;
            end
            rpmc_pkg::RPMC_NORMAL: begin
                o_osc_amp_run   = 1'b1;
                o_divider_run   = 1'b1;
                o_vco_run       = 1'b1;
                o_use_pll_clock = i_pll_locked;
                o_clock_out_en  = 1'b1;
            end
            rpmc_pkg::RPMC_VCO_STOP,
            rpmc_pkg::RPMC_DIV_ONLY: begin
                // The crystal clock is the only source; a looped-back master clock kills it.
                o_osc_amp_run  = 1'b1;
                o_divider_run  = 1'b1;
                o_clock_out_en = !clocks_dead;
            end
            rpmc_pkg::RPMC_AMP_ONLY: begin
                // Only the amplifier runs, feeding the crystal output pin.
                o_osc_amp_run = 1'b1;
            end
            rpmc_pkg::RPMC_AMP_STOP: begin
                // The amplifier is off; the locked PLL alone keeps the clocks alive.
                o_vco_run       = 1'b1;
                o_divider_run   = i_pll_locked;
                o_use_pll_clock = i_pll_locked;
                o_clock_out_en  = !clocks_dead;
            end
            rpmc_pkg::RPMC_ALL_STOP: begin
                // Nothing runs; bit and frame clocks stay frozen in the pin register.
                o_clock_out_en = 1'b0;
            end
        endcase
    end

    rpmc_ratio u_ratio (
        .i_ratio      (state.ctrl.pll_lock_ratio),
        .o_lock_mult  (o_lock_mult),
        .o_half_out   (o_half_out),
        .o_fs_max_khz (o_fs_max_khz)
    );

    assign o_mode        = state.mode;
    assign o_pins        = state.pins;
    assign o_status_data = state.status;

endmodule // rpmc_top

// ==== sim/rpmc_monitor.sv ====
// Concurrent checks on the ports of the receiver power mode controller.
module rpmc_monitor (
    // Clock, reset and live pins
    input wire logic                    i_ref_clk,
    input wire logic                    i_rst_n,
    input wire rpmc_pkg::rpmc_pins_type i_live_pins,
    // Watched outputs
    input wire logic [7:0]              o_status_data,
    input wire rpmc_pkg::rpmc_mode_type o_mode,
    input wire logic                    o_osc_amp_run,
    input wire logic                    o_vco_run,
    input wire logic                    o_use_pll_clock,
    input wire logic                    o_clock_out_en,
    input wire logic [9:0]              o_lock_mult,
    input wire logic [7:0]              o_fs_max_khz,
    input wire rpmc_pkg::rpmc_pins_type o_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    AST_RST_EXIT: assert property (
        $rose(i_rst_n) |-> (o_mode == 7'h01 && o_pins == 9'h086) ##1 o_mode == 7'h02)
        else $error("bad leave of power-down");
    AST_FS_MAX: assert property (
        o_fs_max_khz == ((o_lock_mult == 10'h100) ? 8'hc3 : 8'h6c))
        else $error("bad sample rate ceiling");
    AST_SLEEP_RD: assert property (
        o_mode inside {7'h08, 7'h10} |-> o_status_data == 8'h00)
        else $error("readback not zero in sleep");
    AST_AMP_ONLY: assert property (
        o_mode == 7'h08 |=> !(o_pins.bit_clock_out | o_pins.frame_clock_out | o_pins.serial_audio_out))
        else $error("audio pins not low in sleep");
    AST_HOLD: assert property (
        o_mode == 7'h40 |=> $stable(o_pins.bit_clock_out) && $stable(o_pins.frame_clock_out))
        else $error("bit or frame clock moved in full stop");
    AST_STOP_RUN: assert property (
        o_mode == 7'h40 |-> !(o_osc_amp_run | o_vco_run | o_clock_out_en))
        else $error("clock still enabled in full stop");
    AST_XIN_SRC: assert property (
        o_mode inside {7'h04, 7'h08, 7'h10} |-> !(o_use_pll_clock | o_vco_run))
        else $error("pll source used with vco stopped");
    AST_LIVE: assert property (
        o_mode == 7'h02 |=> o_pins == $past(i_live_pins))
        else $error("pins not live in normal mode");
endmodule // rpmc_monitor
bind rpmc_top rpmc_monitor u_mon (.*);

// ==== sim/rpmc_host_model.sv ====
// Host model: drives the power-down pin and flags when the device may be used.
module rpmc_host_model #(parameter int HOLD = 8, parameter int SETTLE = 4) (
    // Clock and reset request
    input  wire logic i_ref_clk,
    input  wire logic i_pd_req,
    // Power-down pin and ready flag
    output logic      o_rst_n,
    output logic      o_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    int lo = 0;
    int hi = 0;
    // The pin moves in the update region of a rising edge, like every other bench input.
    always @(posedge i_ref_clk) begin
        lo <= i_pd_req ? 0 : (lo < HOLD) ? lo + 1 : lo;
        hi <= !o_rst_n ? 0 : (hi < SETTLE) ? hi + 1 : hi;
    end
    assign o_rst_n = (lo >= HOLD) && !i_pd_req;
    // A short count stands in for the long crystal settle time.
    assign o_ready = (hi >= SETTLE);
endmodule // rpmc_host_model

// ==== sim/rpmc_top_tb.sv ====
// Self-checking testbench of the receiver power mode controller.
module rpmc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, pd_req = 1'b0, we = 1'b0, lock = 1'b1, loop = 1'b0;
    logic rst_n, ready, amp, div, vco, pllc, cen, half;
    logic [7:0] st, fs;
    logic [9:0] mult;
    rpmc_pkg::rpmc_ctrl_type ctrl = '0;
    rpmc_pkg::rpmc_mode_type mode;
    rpmc_pkg::rpmc_pins_type pins;
    rpmc_pkg::rpmc_pins_type live = 9'h1ff;
    int errors = 0;
    int n_checks = 0;
    // Control value, mode and pins, with live pins all high and the PLL locked.
    localparam logic [5:0] CT [6] = '{6'h00, 6'h11, 6'h06, 6'h1b, 6'h20, 6'h34};
    localparam logic [6:0] MT [6] = '{7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40};
    localparam logic [8:0] PT [6] = '{9'h1ff, 9'h0fe, 9'h0c6, 9'h0fe, 9'h1ff, 9'h0b6};
    initial forever #2.5 clk = ~clk;
    rpmc_host_model #(.HOLD(8), .SETTLE(4)) u_host (.i_ref_clk(clk), .i_pd_req(pd_req),
        .o_rst_n(rst_n), .o_ready(ready));
    rpmc_top u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_ctrl(ctrl), .i_ctrl_we(we),
        .i_pll_locked(lock), .i_clock_loopback(loop), .i_live_pins(live),
        .i_status_data(8'ha5), .o_status_data(st), .o_mode(mode), .o_osc_amp_run(amp),
        .o_divider_run(div), .o_vco_run(vco), .o_use_pll_clock(pllc), .o_clock_out_en(cen),
        .o_lock_mult(mult), .o_half_out(half), .o_fs_max_khz(fs), .o_pins(pins));
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wait_ready;
        for (int i = 0; i < 40 && ready !== 1'b1; i++) @(posedge clk);
        if (ready !== 1'b1) begin
            errors++;
            results();
        end
    endtask
    task automatic wr(input logic [5:0] c, input logic lk, input logic lp);
        @(posedge clk);
        ctrl <= c;
        we <= 1'b1;
        lock <= lk;
        loop <= lp;
        @(posedge clk);
        we <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic t_modes;
        for (int i = 0; i < 6; i++) begin
            wr(CT[i], 1'b1, 1'b0);
            chk(mode, MT[i]);
            chk(pins, PT[i]);
            chk(st, (CT[i][3:2] != 2'h0) ? 8'h00 : 8'ha5);
            chk(mult, (CT[i][1:0] == 2'h0) ? 10'h100 :
                (CT[i][1:0] == 2'h1) ? 10'h180 : 10'h200);
            chk({half, fs}, {CT[i][1:0] == 2'h3, (CT[i][1:0] == 2'h0) ? 8'hc3 : 8'h6c});
        end
        $display("mode table test done");
    endtask
    task automatic t_dead;
        wr(6'h20, 1'b0, 1'b0);
        chk({cen, pins.master_clock_out}, 2'h0);
        wr(6'h10, 1'b1, 1'b1);
        chk({cen, pllc, vco}, 3'h0);
        wr(6'h00, 1'b1, 1'b0);
        chk({cen, pllc, vco}, 3'h7);
        @(posedge clk);
        live <= 9'h125;
        repeat (2) @(posedge clk);
        #1;
        chk(pins, 9'h125);
        wr(6'h28, 1'b1, 1'b0);
        chk({mode, amp, vco, cen}, {7'h40, 3'h0});
        chk(pins, 9'h026);
        $display("clock loss test done");
    endtask
    task automatic t_reset;
        wr(6'h11, 1'b1, 1'b0);
        @(posedge clk);
        pd_req <= 1'b1;
        wr(6'h34, 1'b1, 1'b0);
        chk(mode, 7'h01);
        chk(pins, 9'h086);
        chk({st, amp, vco, div, cen, mult}, {12'h000, 10'h100});
        @(posedge clk);
        pd_req <= 1'b0;
        wait_ready;
        #1;
        chk(mode, 7'h02);
        $display("power-down test done");
    endtask
    initial begin
        wait_ready;
        #1;
        chk(mode, 7'h02);
        t_modes;
        t_dead;
        t_reset;
        results;
    end
endmodule // rpmc_top_tb
